// ---- ofcm_pkg.sv ----
// constants, register map and types for the over-range flag and clock-out mux
package ofcm_pkg;
  localparam int SAMPLE_W = 12;
  localparam int HOLD_W = 8;
  localparam int NUM_EVT = 5;
  localparam int ADDR_W = 12;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_THRESH = 12'h004;
  localparam logic [11:0] OFF_HOLD = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_INT_STATUS = 12'h010;
  localparam logic [11:0] OFF_INT_MASK = 12'h014;
  // control register fields
  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_CFGC_LSB = 1;
  localparam int CTRL_CFGD_LSB = 3;
  localparam int CTRL_DIS_BIT = 5;
  localparam int CTRL_W = 6;
  // status register fields
  localparam int ST_FLAG_LSB = 0;
  localparam int ST_PINCFG_LSB = 4;
  localparam int ST_PLLEN_BIT = 6;
  localparam int ST_PD_BIT = 7;
  localparam int ST_CCLK_BIT = 8;
  localparam int ST_DCLK_BIT = 9;
  // interrupt bits: 0..3 flag rise per channel, 4 clock output on C lost
  localparam int EVT_CLK_LOST = 4;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [SAMPLE_W-1:0] THRESH_RST = 12'h800;
  localparam logic [HOLD_W-1:0] HOLD_RST = 8'h08;
  localparam logic [NUM_EVT-1:0] MASK_RST = 5'h00;
  // clock output configuration codes
  localparam logic [1:0] CFG_FLAG = 2'h0;
  localparam logic [1:0] CFG_DIV1 = 2'h1;
  localparam logic [1:0] CFG_DIV2 = 2'h2;
  localparam logic [1:0] CFG_DIV4 = 2'h3;
  // reference output half period in ref_clk cycles
  localparam int REF_HALF = 2;
  typedef enum logic [0:0] {
    OFCM_IDLE = 1'b0,
    OFCM_HOLD = 1'b1
  } ofcm_hold_state_t;
endpackage

// ---- ofcm_div_if.sv ----
// carrier between the reference divider and the output mux
`timescale 1ns/100ps
interface ofcm_div_if;
  logic run;
  logic refOut;
  logic div2;
  logic div4;
  modport gen (
    input run,
    output refOut,
    output div2,
    output div4
  );
  modport use_side (
    output run,
    input refOut,
    input div2,
    input div4
  );
endinterface

// ---- ofcm_refdiv.sv ----
// reference output clock generator with synchronous divide-by-2 and divide-by-4
`timescale 1ns/100ps
module ofcm_refdiv #(
  parameter int REF_HALF = ofcm_pkg::REF_HALF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  ofcm_div_if.gen div
);
  logic [7:0] halfCnt;
  logic halfEnd;

  assign halfEnd = (halfCnt == 8'(REF_HALF - 1));

  always_ff @(posedge ref_clk) begin
    if (!rstn || !div.run) begin
      halfCnt <= 8'h00;
    end else if (halfEnd) begin
      halfCnt <= 8'h00;
    end else begin
      halfCnt <= 8'(halfCnt + 8'h01);
    end
  end

  // all three toggle on the same edge as their source rises, so edges stay aligned
  always_ff @(posedge ref_clk) begin
    if (!rstn || !div.run) begin
      div.refOut <= 1'b0;
      div.div2 <= 1'b0;
      div.div4 <= 1'b0;
    end else if (halfEnd) begin
      div.refOut <= ~div.refOut;
      if (!div.refOut) begin
        div.div2 <= ~div.div2;
        if (!div.div2) begin
          div.div4 <= ~div.div4;
        end
      end
    end
  end
endmodule

// ---- ofcm_top.sv ----
// over-range flag outputs and clock-out mux for the C and D flag pins
`timescale 1ns/100ps
module ofcm_top #(
  parameter int NUM_CHANNELS = 4,
  parameter int REF_HALF = ofcm_pkg::REF_HALF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ofcm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4*ofcm_pkg::SAMPLE_W-1:0] sampleData,
  input wire logic sampleValid,
  input wire logic [1:0] clock_output_config_pins,
  input wire logic pllEnablePin,
  input wire logic power_down_pin,
  output logic overrange_flag_a,
  output logic overrange_flag_b,
  output logic overrange_flag_c_or_clock,
  output logic overrange_flag_d_or_clock,
  output logic pll_reference_clock_out,
  output logic irq
);
  localparam int SW = ofcm_pkg::SAMPLE_W;
  localparam int HW = ofcm_pkg::HOLD_W;
  localparam int NE = ofcm_pkg::NUM_EVT;

  // registers
  logic [ofcm_pkg::CTRL_W-1:0] ctrl;
  logic [SW-1:0] overrange_threshold;
  logic [HW-1:0] overrange_hold_count;
  logic [NE-1:0] intStatus;
  logic [NE-1:0] intMask;

  // synchronised pins
  logic [3:0] pinRaw;
  logic [3:0] pinS1;
  logic [3:0] pinS2;
  logic [3:0] pinS3;
  logic [3:0] pinStable;
  logic [1:0] cfgPins;
  logic pllEn;
  logic pwrDown;

  // flags
  logic [3:0] flag;
  logic [3:0] flagPrev;
  logic [3:0] overNow;
  logic [3:0] chanEn;

  // clock selection
  logic clkOverride;
  logic clkDisable;
  logic [1:0] cfgC;
  logic [1:0] cfgD;
  logic clockAllowed;
  logic cClkOn;
  logic dClkOn;
  logic cClkPrev;
  logic cFlagMode;
  logic dFlagMode;
  logic cClkSel;
  logic dClkSel;
  logic [NE-1:0] evt;

  // bus
  logic setupPh;
  logic accessDone;
  logic wrDone;
  logic addrHit;
  logic [31:0] rdValue;
  logic [31:0] statusWord;

  ofcm_div_if divBus ();

  ofcm_refdiv #(
    .REF_HALF(REF_HALF)
  ) u_refdiv (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .div(divBus)
  );

  // pin synchronisers: a change counts once stages two and three agree
  assign pinRaw = {power_down_pin, pllEnablePin, clock_output_config_pins};

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          pinS1[gp] <= 1'b0;
          pinS2[gp] <= 1'b0;
          pinS3[gp] <= 1'b0;
          pinStable[gp] <= 1'b0;
        end else begin
          pinS1[gp] <= pinRaw[gp];
          pinS2[gp] <= pinS1[gp];
          pinS3[gp] <= pinS2[gp];
          if (pinS2[gp] == pinS3[gp]) begin
            pinStable[gp] <= pinS3[gp];
          end
        end
      end
    end
  endgenerate

  assign cfgPins = pinStable[1:0];
  assign pllEn = pinStable[2];
  assign pwrDown = pinStable[3];

  // per-channel detect and hold
  genvar gc;
  generate
    for (gc = 0; gc < 4; gc++) begin : g_chan
      logic [SW-1:0] smp;
      logic [SW-1:0] mag;
      logic [HW-1:0] holdCnt;
      ofcm_pkg::ofcm_hold_state_t state;

      // single variant drops B, only quad keeps C and D
      assign chanEn[gc] = (gc < NUM_CHANNELS);
      assign smp = sampleData[gc*SW +: SW];
      assign mag = smp[SW-1] ? SW'(~smp + 1'b1) : smp;
      assign overNow[gc] = chanEn[gc] && sampleValid && (mag > overrange_threshold);

      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          state <= ofcm_pkg::OFCM_IDLE;
          holdCnt <= '0;
          flag[gc] <= 1'b0;
        end else begin
          case (state)
            ofcm_pkg::OFCM_IDLE: begin
              if (overNow[gc]) begin
                state <= ofcm_pkg::OFCM_HOLD;
                holdCnt <= overrange_hold_count;
                flag[gc] <= 1'b1;
              end
            end
            ofcm_pkg::OFCM_HOLD: begin
              // every new over-range sample restarts the minimum time
              if (overNow[gc]) begin
                holdCnt <= overrange_hold_count;
              end else if (holdCnt == '0) begin
                state <= ofcm_pkg::OFCM_IDLE;
                flag[gc] <= 1'b0;
              end else begin
                holdCnt <= HW'(holdCnt - 1'b1);
              end
            end
            default: begin
              state <= ofcm_pkg::OFCM_IDLE;
              flag[gc] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // clock output selection
  assign clkOverride = ctrl[ofcm_pkg::CTRL_OVR_BIT];
  assign clkDisable = ctrl[ofcm_pkg::CTRL_DIS_BIT];

  always_comb begin
    if (clkDisable) begin
      cfgC = ofcm_pkg::CFG_FLAG;
    end else if (clkOverride) begin
      cfgC = ctrl[ofcm_pkg::CTRL_CFGC_LSB +: 2];
    end else begin
      cfgC = cfgPins;
    end
  end

  always_comb begin
    if (clkDisable) begin
      cfgD = ofcm_pkg::CFG_FLAG;
    end else if (clkOverride) begin
      cfgD = ctrl[ofcm_pkg::CTRL_CFGD_LSB +: 2];
    end else if (cfgPins != ofcm_pkg::CFG_FLAG) begin
      cfgD = ofcm_pkg::CFG_DIV1;
    end else begin
      cfgD = ofcm_pkg::CFG_FLAG;
    end
  end

  assign clockAllowed = pllEn && !pwrDown;
  assign divBus.run = clockAllowed;
  assign cClkOn = clockAllowed && (cfgC != ofcm_pkg::CFG_FLAG);
  assign dClkOn = cClkOn && (cfgD != ofcm_pkg::CFG_FLAG);
  assign cFlagMode = (cfgC == ofcm_pkg::CFG_FLAG);
  assign dFlagMode = cFlagMode || (cfgD == ofcm_pkg::CFG_FLAG);

  always_comb begin
    case (cfgC)
      ofcm_pkg::CFG_DIV1: cClkSel = divBus.refOut;
      ofcm_pkg::CFG_DIV2: cClkSel = divBus.div2;
      ofcm_pkg::CFG_DIV4: cClkSel = divBus.div4;
      default: cClkSel = 1'b0;
    endcase
  end

  always_comb begin
    case (cfgD)
      ofcm_pkg::CFG_DIV1: dClkSel = divBus.refOut;
      ofcm_pkg::CFG_DIV2: dClkSel = divBus.div2;
      ofcm_pkg::CFG_DIV4: dClkSel = divBus.div4;
      default: dClkSel = 1'b0;
    endcase
  end

  // pins register the mux so every output leaves a flip-flop; all lag one cycle alike
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      overrange_flag_a <= 1'b0;
      overrange_flag_b <= 1'b0;
      overrange_flag_c_or_clock <= 1'b0;
      overrange_flag_d_or_clock <= 1'b0;
      pll_reference_clock_out <= 1'b0;
    end else begin
      overrange_flag_a <= flag[0];
      overrange_flag_b <= flag[1];
      pll_reference_clock_out <= divBus.refOut;
      // a clock selection without PLL parks the pin low rather than showing flags
      if (cClkOn) begin
        overrange_flag_c_or_clock <= cClkSel;
      end else if (cFlagMode) begin
        overrange_flag_c_or_clock <= flag[2];
      end else begin
        overrange_flag_c_or_clock <= 1'b0;
      end
      if (dClkOn) begin
        overrange_flag_d_or_clock <= dClkSel;
      end else if (dFlagMode) begin
        overrange_flag_d_or_clock <= flag[3];
      end else begin
        overrange_flag_d_or_clock <= 1'b0;
      end
    end
  end

  // events
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flagPrev <= 4'h0;
      cClkPrev <= 1'b0;
    end else begin
      flagPrev <= flag;
      cClkPrev <= cClkOn;
    end
  end

  assign evt = {cClkPrev && !cClkOn, flag & ~flagPrev};

  // APB slave: no wait states, read data captured in the setup cycle
  assign setupPh = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign wrDone = accessDone && pwrite;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[ofcm_pkg::ST_FLAG_LSB +: 4] = flag;
    statusWord[ofcm_pkg::ST_PINCFG_LSB +: 2] = cfgPins;
    statusWord[ofcm_pkg::ST_PLLEN_BIT] = pllEn;
    statusWord[ofcm_pkg::ST_PD_BIT] = pwrDown;
    statusWord[ofcm_pkg::ST_CCLK_BIT] = cClkOn;
    statusWord[ofcm_pkg::ST_DCLK_BIT] = dClkOn;
  end

  always_comb begin
    rdValue = 32'h0000_0000;
    addrHit = 1'b1;
    case (paddr)
      ofcm_pkg::OFF_CTRL: rdValue[ofcm_pkg::CTRL_W-1:0] = ctrl;
      ofcm_pkg::OFF_THRESH: rdValue[SW-1:0] = overrange_threshold;
      ofcm_pkg::OFF_HOLD: rdValue[HW-1:0] = overrange_hold_count;
      ofcm_pkg::OFF_STATUS: rdValue = statusWord;
      ofcm_pkg::OFF_INT_STATUS: rdValue[NE-1:0] = intStatus;
      ofcm_pkg::OFF_INT_MASK: rdValue[NE-1:0] = intMask;
      default: addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPh;
      if (setupPh) begin
        pslverr <= !addrHit;
        prdata <= (pwrite || !addrHit) ? 32'h0000_0000 : rdValue;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl <= ofcm_pkg::CTRL_RST;
      overrange_threshold <= ofcm_pkg::THRESH_RST;
      overrange_hold_count <= ofcm_pkg::HOLD_RST;
      intMask <= ofcm_pkg::MASK_RST;
    end else if (wrDone) begin
      case (paddr)
        ofcm_pkg::OFF_CTRL: ctrl <= pwdata[ofcm_pkg::CTRL_W-1:0];
        ofcm_pkg::OFF_THRESH: overrange_threshold <= pwdata[SW-1:0];
        ofcm_pkg::OFF_HOLD: overrange_hold_count <= pwdata[HW-1:0];
        ofcm_pkg::OFF_INT_MASK: intMask <= pwdata[NE-1:0];
        default: ;
      endcase
    end
  end

  // new events win over a write-one-to-clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      intStatus <= '0;
    end else if (wrDone && (paddr == ofcm_pkg::OFF_INT_STATUS)) begin
      intStatus <= (intStatus & ~pwdata[NE-1:0]) | evt;
    end else begin
      intStatus <= intStatus | evt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus & intMask);
    end
  end
endmodule

// ---- ofcm_checker.sv ----
// port-level assertions for APB timing, over-range flag A and the PLL reference clock output
`timescale 1ns/100ps
module ofcm_checker #(
  parameter int NUM_CHANNELS = 4,
  parameter int REF_HALF = 2
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ofcm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4*ofcm_pkg::SAMPLE_W-1:0] sampleData,
  input wire logic sampleValid,
  input wire logic pllEnablePin,
  input wire logic power_down_pin,
  input wire logic overrange_flag_a,
  input wire logic pll_reference_clock_out,
  input wire logic irq
);
  logic [11:0] thresh;
  logic [7:0] hold;
  logic [3:0] offCnt;
  int hiCnt;
  int aCnt;
  logic wr;
  logic [12:0] magA;
  logic overA;
  assign wr = psel && penable && pready && pwrite;
  assign magA = sampleData[11] ? 13'h1000 - {1'b0, sampleData[11:0]} : {1'b0, sampleData[11:0]};
  assign overA = sampleValid && (magA > {1'b0, thresh});
  // shadow of the threshold and hold registers, snooped from completed writes
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      thresh <= ofcm_pkg::THRESH_RST;
      hold <= ofcm_pkg::HOLD_RST;
    end else if (wr && paddr == ofcm_pkg::OFF_THRESH) begin
      thresh <= pwdata[11:0];
    end else if (wr && paddr == ofcm_pkg::OFF_HOLD) begin
      hold <= pwdata[7:0];
    end
  end
  // pins pass a synchroniser, so the clock may stop a few cycles late
  always_ff @(posedge ref_clk) begin
    if (!rstn || !(power_down_pin || !pllEnablePin)) offCnt <= 4'h0;
    else if (offCnt != 4'hF) offCnt <= offCnt + 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    hiCnt <= (rstn && pll_reference_clock_out) ? hiCnt + 1 : 0;
    aCnt <= (rstn && overrange_flag_a) ? aCnt + 1 : 0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_answer)
    else $error("pready not one cycle after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_reset_quiet: assert property ($rose(rstn) |-> !irq && !pready && !overrange_flag_a)
    else $error("outputs not low out of reset");
  a_flag_follows: assert property (overA |-> ##2 overrange_flag_a)
    else $error("flag A missing after over sample");
  a_flag_cause: assert property ($rose(overrange_flag_a) |-> $past(overA, 2))
    else $error("flag A rose without over sample");
  a_flag_hold: assert property ($fell(overrange_flag_a) |-> aCnt >= hold + 1)
    else $error("flag A pulse too short");
  a_ref_stops: assert property (offCnt >= 4'h8 |-> !pll_reference_clock_out)
    else $error("reference clock runs while stopped");
  a_ref_high_max: assert property (pll_reference_clock_out |-> hiCnt < REF_HALF)
    else $error("reference clock high too long");
  a_ref_high_len: assert property ($fell(pll_reference_clock_out) && offCnt == 4'h0
    |-> hiCnt == REF_HALF)
    else $error("reference clock high phase wrong");
endmodule
bind ofcm_top ofcm_checker #(.NUM_CHANNELS(NUM_CHANNELS), .REF_HALF(REF_HALF)) i_chk (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .sampleData(sampleData), .sampleValid(sampleValid), .pllEnablePin(pllEnablePin),
  .power_down_pin(power_down_pin), .overrange_flag_a(overrange_flag_a),
  .pll_reference_clock_out(pll_reference_clock_out), .irq(irq));

// ---- ofcm_tb_top.sv ----
// self-checking bench for the over-range flag and clock-out mux
`timescale 1ns/100ps
module ofcm_tb_top;
  localparam int RH = 2;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [47:0] sampleData = 48'h0;
  logic sampleValid = 1'b0;
  logic [1:0] cfgPins = 2'h0;
  logic pllEn = 1'b1;
  logic pd = 1'b0;
  logic [3:0] flags;
  logic refOut;
  logic irq;
  logic [31:0] rd;
  logic err;
  logic [11:0] t;
  logic [7:0] h;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  ofcm_top #(.NUM_CHANNELS(4), .REF_HALF(RH)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleData(sampleData), .sampleValid(sampleValid),
    .clock_output_config_pins(cfgPins), .pllEnablePin(pllEn), .power_down_pin(pd),
    .overrange_flag_a(flags[0]), .overrange_flag_b(flags[1]),
    .overrange_flag_c_or_clock(flags[2]), .overrange_flag_d_or_clock(flags[3]),
    .pll_reference_clock_out(refOut), .irq(irq));
  always #4 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      $display("Error %0t: run timed out", $time);
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic len_ok(input int cnt, input int hc, input logic over);
    return over ? (cnt >= hc + 1 && cnt <= hc + 2) : (cnt == 0);
  endfunction
  function automatic int exp_rises(input int div);
    return (div == 0) ? 0 : 64 / (2 * RH * div);
  endfunction
  task automatic flag_case(input int ch, input logic [11:0] v, input logic vld,
                           input logic over);
    logic [47:0] s;
    int cnt;
    s = 48'h0;
    s[12*ch +: 12] = v;
    cnt = 0;
    @(posedge ref_clk);
    sampleData <= s;
    sampleValid <= vld;
    @(posedge ref_clk);
    sampleData <= 48'h0;
    sampleValid <= 1'b1;
    repeat (int'(h) + 12) begin
      @(posedge ref_clk);
      cnt += int'(flags[ch]);
    end
    chk(32'(len_ok(cnt, int'(h), over)), 32'h1);
  endtask
  task automatic clk_case(input logic [1:0] pins, input logic [31:0] ctrl, input logic pl,
                          input logic pdv, input int dr, input int dc, input int dd);
    int nr;
    int nc;
    int nd;
    logic [2:0] p;
    cfgPins <= pins;
    pllEn <= pl;
    pd <= pdv;
    apb(1'b1, ofcm_pkg::OFF_CTRL, ctrl);
    repeat (12) @(posedge ref_clk);
    nr = 0;
    nc = 0;
    nd = 0;
    p = {refOut, flags[2], flags[3]};
    repeat (64) begin
      @(posedge ref_clk);
      nr += int'(refOut && !p[2]);
      nc += int'(flags[2] && !p[1]);
      nd += int'(flags[3] && !p[0]);
      p = {refOut, flags[2], flags[3]};
    end
    chk(32'(nr), 32'(exp_rises(dr)));
    chk(32'(nc), 32'(exp_rises(dc)));
    chk(32'(nd), 32'(exp_rises(dd)));
  endtask
  initial begin
    void'($urandom(32'h5CE0));
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(1'b0, ofcm_pkg::OFF_THRESH, 32'h0);
    chk(rd & 32'hFFF, 32'h800);
    apb(1'b0, ofcm_pkg::OFF_HOLD, 32'h0);
    chk(rd & 32'hFF, 32'h08);
    apb(1'b0, 12'h040, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test registers done");
    t = 12'h100 + 12'($urandom_range(32'h600));
    h = 8'($urandom_range(9, 2));
    apb(1'b1, ofcm_pkg::OFF_THRESH, {20'h0, t});
    apb(1'b1, ofcm_pkg::OFF_HOLD, {24'h0, h});
    for (int ch = 0; ch < 4; ch++) begin
      flag_case(ch, $urandom_range(1) ? ~t : t + 12'h1, 1'b1, 1'b1);
      flag_case(ch, ch[0] ? t : 12'h0 - t, 1'b1, 1'b0);
      flag_case(ch, 12'h7FF, 1'b0, 1'b0);
    end
    apb(1'b0, ofcm_pkg::OFF_INT_STATUS, 32'h0);
    chk(rd & 32'h1F, 32'h0F);
    apb(1'b1, ofcm_pkg::OFF_INT_STATUS, 32'h1F);
    apb(1'b0, ofcm_pkg::OFF_INT_STATUS, 32'h0);
    chk(rd & 32'h1F, 32'h00);
    $display("test flags done");
    apb(1'b1, ofcm_pkg::OFF_INT_MASK, 32'h1);
    flag_case(1, t + 12'h1, 1'b1, 1'b1);
    chk({31'h0, irq}, 32'h0);
    flag_case(0, ~t, 1'b1, 1'b1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ofcm_pkg::OFF_INT_STATUS, 32'h03);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    clk_case(2'h1, 32'h00, 1'b1, 1'b0, 1, 1, 1);
    // synced pins 01, pll on, C and D both clocking
    apb(1'b0, ofcm_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h350);
    clk_case(2'h2, 32'h00, 1'b1, 1'b0, 1, 2, 1);
    clk_case(2'h3, 32'h00, 1'b1, 1'b0, 1, 4, 1);
    clk_case(2'h0, 32'h15, 1'b1, 1'b0, 1, 2, 2);
    clk_case(2'h0, 32'h1F, 1'b1, 1'b0, 1, 4, 4);
    clk_case(2'h1, 32'h09, 1'b1, 1'b0, 1, 0, 0);
    clk_case(2'h1, 32'h20, 1'b1, 1'b0, 1, 0, 0);
    clk_case(2'h1, 32'h00, 1'b1, 1'b1, 0, 0, 0);
    clk_case(2'h1, 32'h00, 1'b0, 1'b0, 0, 0, 0);
    // C stopped clocking when the override turned it off, and no flag rose since
    apb(1'b0, ofcm_pkg::OFF_INT_STATUS, 32'h0);
    chk(rd & 32'h1F, 32'h10);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ofcm_pkg::OFF_INT_MASK, 32'h10);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    $display("test clock mux done");
    stop_test();
  end
endmodule
